// ==== hdl/lf_timers_pkg.sv ====
/*
 * constants for the low-frequency wake-up supervision timers:
 * clock rates, time-outs, derived tick counts, counter widths, states.
 * assumes a 10 MHz system clock and a 32 kHz internal timer tick.
 */
package lf_timers_pkg;
	// clock rates
	localparam int MCLK_HZ = 10_000_000;
	localparam int LFCLK_HZ = 32_000;
	// system clocks per 32 kHz tick, rounded down
	localparam int TICK_DIV = MCLK_HZ / LFCLK_HZ;
	// nominal times in microseconds
	localparam int INACT_US = 16_000;
	localparam int ALARM_US = 32_000;
	localparam int SETTLE_US = 3_500;
	localparam int POST_SETTLE_US = 500;
	// the same times as counts of 32 kHz ticks
	localparam int INACT_TICKS = INACT_US * (LFCLK_HZ / 1000) / 1000;
	localparam int ALARM_TICKS = ALARM_US * (LFCLK_HZ / 1000) / 1000;
	localparam int SETTLE_TICKS = SETTLE_US * (LFCLK_HZ / 1000) / 1000;
	localparam int POST_TICKS = POST_SETTLE_US * (LFCLK_HZ / 1000) / 1000;
	// counter widths
	localparam int DIV_W = 16;
	localparam int INACT_W = 12;
	localparam int ALARM_W = 12;
	localparam int SETTLE_W = 8;
	localparam int HDR_W = 8;
	localparam int PER_W = 9;
	localparam int NCH = 3;
	// header check states, gray along the usual path
	typedef enum logic [2:0] {
		ST_STANDBY = 3'h0,
		ST_SETTLE = 3'h1,
		ST_POST = 3'h3,
		ST_HUNT = 3'h2,
		ST_HIGH = 3'h6,
		ST_LOW = 3'h7,
		ST_PASS = 3'h5
	} state_t;
endpackage

// ==== hdl/lf_wakeup_supervision_timers.sv ====
/*
 * supervision timers of the low-frequency wake-up front end:
 * inactivity, alarm, pulse width, period and gain settling timers,
 * plus the header check of the output enable filter.
 * assumes demodulated channel levels and chip select arrive as
 * asynchronous pins; configuration comes from same-clock logic.
 * every output leaves from a flip-flop; slower rates come from a
 * one-cycle tick enable, so the whole block runs on the one clock.
 * the synchronisers carry no reset: hold the pins idle during reset.
 */
`timescale 1ns/1ps
module lf_wakeup_supervision_timers
	import lf_timers_pkg::*;
#(
	// shorten for simulation; tick rate and time-outs in ticks
	// defaults give the nominal time-outs at the 32 kHz tick
	parameter int TICK_CYCLES = TICK_DIV,
	parameter int INACT_COUNT = INACT_TICKS,
	parameter int ALARM_COUNT = ALARM_TICKS,
	parameter int SETTLE_COUNT = SETTLE_TICKS,
	parameter int POST_COUNT = POST_TICKS
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// demodulated channel levels and serial select pins
	input wire logic [NCH-1:0] LF_IN,
	input wire logic CS_N,
	// configuration
	input wire logic OE_FILTER_EN,
	input wire logic RSSI_MODE,
	input wire logic [HDR_W-1:0] HEADER_HIGH_MIN,
	input wire logic [HDR_W-1:0] HEADER_LOW_MIN,
	input wire logic [PER_W-1:0] HEADER_PERIOD_MAX,
	// alarm and status
	output logic ALERT_N,
	output logic ALARM_FLAG,
	output logic [NCH-1:0] CHANNEL_WOKE,
	// front end power and filter control
	output logic STANDBY,
	output logic SOFT_RESET,
	output logic FILTER_RST,
	output logic DATA_OUT_EN,
	output logic DEMOD_DATA_OUT
);

	// input synchronisers
	logic [NCH-1:0] lf_m_q; // first stage
	logic [NCH-1:0] lf_s_q; // second stage
	logic cs_m_q; // first stage
	logic cs_s_q; // second stage
	logic lf_any_q; // previous combined level
	logic cs_prev_q; // previous select level

	// tick divider
	logic [DIV_W-1:0] div_q;
	logic tick;

	// timers
	logic [INACT_W-1:0] inact_q;
	logic [ALARM_W-1:0] alarm_q;
	logic [HDR_W-1:0] hdr_q;
	logic [PER_W-1:0] per_q;
	logic [HDR_W-1:0] post_q;
	logic [NCH-1:0] settled;

	// control state
	state_t state_q;
	state_t state_d;
	logic seen_q; // a signal has been received
	logic soft_q; // registered soft reset
	logic soft_d;
	logic abort_d; // post-settle drop

	// output registers
	logic alarm_flag_q;
	logic alert_n_q; // alert pin level, low while alarmed
	logic [NCH-1:0] woke_q;
	logic standby_q;
	logic filter_rst_q;
	logic data_en_q;
	logic data_q;

	// combined and edge terms
	wire lf_any = |lf_s_q;
	wire lf_rise = lf_any & ~lf_any_q;
	wire lf_fall = ~lf_any & lf_any_q;
	wire lf_edge = lf_rise | lf_fall;
	wire cs_low = ~cs_s_q;
	wire cs_fall = cs_prev_q & ~cs_s_q;
	wire timers_on = ~RSSI_MODE;
	wire in_hdr = (state_q == ST_HIGH) || (state_q == ST_LOW);
	wire per_over = per_q > HEADER_PERIOD_MAX;
	wire high_ok = hdr_q >= HEADER_HIGH_MIN;
	wire low_ok = hdr_q >= HEADER_LOW_MIN;
	wire inact_hit = timers_on & seen_q & (inact_q == INACT_W'(INACT_COUNT));
	wire alarm_run = timers_on & seen_q & OE_FILTER_EN & (state_q != ST_PASS);
	wire alarm_hit = alarm_run & (alarm_q == ALARM_W'(ALARM_COUNT));
	// alarm sets once, on the tick that completes the count;
	// a saturated count must not keep overriding the command clear
	wire alarm_set = tick & ~cs_low & alarm_run & (alarm_q == ALARM_W'(ALARM_COUNT - 1));
	wire post_done = post_q == HDR_W'(POST_COUNT);

	// two-flop synchronisers; only the second stage is read
	// no reset here; drive the pins idle while reset is held
	always_ff @(posedge MCLK) begin
		lf_m_q <= LF_IN;
		lf_s_q <= lf_m_q;
		cs_m_q <= CS_N;
		cs_s_q <= cs_m_q;
	end

	// previous levels for edge detection
	// reset values match the idle pin levels, so no false edge follows
	always_ff @(posedge MCLK) begin
		if (RST) begin
			lf_any_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			lf_any_q <= lf_any;
			cs_prev_q <= cs_s_q;
		end
	end

	// 32 kHz tick enable from the system clock
	// free-running; every slower count steps only on this pulse
	assign tick = div_q == DIV_W'(TICK_CYCLES - 1);
	always_ff @(posedge MCLK) begin
		if (RST || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// signal-seen latch, cleared by soft reset
	// arms the inactivity and alarm counts until the next soft reset
	always_ff @(posedge MCLK) begin
		if (RST || soft_q) begin
			seen_q <= 1'b0;
		end else if (lf_any) begin
			seen_q <= 1'b1;
		end
	end

	// inactivity timer
	// saturates at the time-out; the soft reset it raises clears it
	always_ff @(posedge MCLK) begin
		if (RST || soft_q || lf_edge || cs_low || !timers_on) begin
			inact_q <= '0;
		end else if (seen_q && tick && !inact_hit) begin
			inact_q <= inact_q + 1'b1;
		end
	end

	// alarm timer
	// cleared during commands, with the filter off and after a pass
	always_ff @(posedge MCLK) begin
		if (RST || soft_q || cs_low || !alarm_run) begin
			alarm_q <= '0;
		end else if (tick && !alarm_hit) begin
			alarm_q <= alarm_q + 1'b1;
		end
	end

	// alarm flag; no time-out sets while select is low, so none meets the command clear
	// the alert pin has its own flop so that it leaves a register
	always_ff @(posedge MCLK) begin
		if (RST) begin
			alarm_flag_q <= 1'b0;
			alert_n_q <= 1'b1; // alert released
		end else if (alarm_set) begin
			alarm_flag_q <= 1'b1;
			alert_n_q <= 1'b0;
		end else if (cs_fall) begin
			alarm_flag_q <= 1'b0; // host command clears
			alert_n_q <= 1'b1;
		end
	end

	// per-channel gain settling timers
	// one counter per channel; a low on its own input starts it over
	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_settle
			logic [SETTLE_W-1:0] cnt_q;
			assign settled[ch] = cnt_q == SETTLE_W'(SETTLE_COUNT);
			always_ff @(posedge MCLK) begin
				if (RST || state_q != ST_SETTLE || !lf_s_q[ch]) begin
					cnt_q <= '0;
				end else if (tick && !settled[ch]) begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	endgenerate

	// post-settle high timer
	// runs only in the post-settle state; a drop there aborts
	always_ff @(posedge MCLK) begin
		if (RST || state_q != ST_POST) begin
			post_q <= '0;
		end else if (tick && !post_done) begin
			post_q <= post_q + 1'b1;
		end
	end

	// pulse width timer, restarted on each level change
	// saturates rather than wrapping, so a long phase still reads long
	always_ff @(posedge MCLK) begin
		if (RST || lf_edge || !in_hdr) begin
			hdr_q <= '0;
		end else if (tick && hdr_q != '1) begin
			hdr_q <= hdr_q + 1'b1;
		end
	end

	// period timer across the high and low phases
	// stops once over the limit; the header check then hunts again
	always_ff @(posedge MCLK) begin
		if (RST || !in_hdr) begin
			per_q <= '0;
		end else if (tick && !per_over) begin
			per_q <= per_q + 1'b1;
		end
	end

	// header check sequence
	// signal strength mode or a soft reset overrides every state
	always_comb begin
		state_d = state_q;
		abort_d = 1'b0;
		if (!timers_on || soft_q) begin
			state_d = ST_STANDBY;
		end else begin
			case (state_q)
				ST_STANDBY: begin
					if (lf_any) begin
						state_d = ST_SETTLE;
					end
				end
				// filter held in reset while gain settles
				ST_SETTLE: begin
					if (|settled) begin
						state_d = ST_POST;
					end
				end
				// input must stay high after settling
				ST_POST: begin
					if (!lf_any) begin
						abort_d = 1'b1;
						state_d = ST_STANDBY;
					end else if (post_done) begin
						state_d = OE_FILTER_EN ? ST_HUNT : ST_PASS;
					end
				end
				// wait for the header high to begin
				ST_HUNT: begin
					if (lf_rise) begin
						state_d = ST_HIGH;
					end
				end
				// high phase: long enough and within period
				ST_HIGH: begin
					if (per_over) begin
						state_d = ST_HUNT;
					end else if (lf_fall) begin
						state_d = high_ok ? ST_LOW : ST_HUNT;
					end
				end
				// low phase: long enough and within period
				ST_LOW: begin
					if (per_over) begin
						state_d = ST_HUNT;
					end else if (lf_rise) begin
						state_d = low_ok ? ST_PASS : ST_HUNT;
					end
				end
				// header matched or filter off; data flows until soft reset or strength mode
				ST_PASS: begin
					state_d = ST_PASS;
				end
				default: begin
					state_d = ST_STANDBY;
				end
			endcase
		end
	end

	// soft reset sources
	// one-cycle pulse; the registered copy blocks a second one at once
	assign soft_d = timers_on & ~soft_q & (inact_hit | abort_d);

	// state and soft reset registers
	always_ff @(posedge MCLK) begin
		if (RST) begin
			state_q <= ST_STANDBY;
			soft_q <= 1'b0;
		end else begin
			state_q <= state_d;
			soft_q <= soft_d;
		end
	end

	// channel wake indicators, several may set together
	// bits only collect while settling and clear on soft reset
	always_ff @(posedge MCLK) begin
		if (RST || soft_q) begin
			woke_q <= '0;
		end else if (state_q == ST_SETTLE) begin
			woke_q <= woke_q | settled;
		end
	end

	// power, filter and data output controls
	// taken from the next state so the outputs line up with the state
	always_ff @(posedge MCLK) begin
		if (RST) begin
			standby_q <= 1'b1;
			filter_rst_q <= 1'b1;
			data_en_q <= 1'b0;
			data_q <= 1'b0;
		end else begin
			// signal strength mode runs active at once
			standby_q <= timers_on & (state_d == ST_STANDBY);
			filter_rst_q <= (state_d == ST_STANDBY) || (state_d == ST_SETTLE);
			data_en_q <= state_d == ST_PASS;
			data_q <= (state_d == ST_PASS) & lf_any;
		end
	end

	// outputs straight from flip-flops
	assign ALERT_N = alert_n_q;
	assign ALARM_FLAG = alarm_flag_q;
	assign CHANNEL_WOKE = woke_q;
	assign STANDBY = standby_q;
	assign SOFT_RESET = soft_q;
	assign FILTER_RST = filter_rst_q;
	assign DATA_OUT_EN = data_en_q;
	assign DEMOD_DATA_OUT = data_q;

endmodule // lf_wakeup_supervision_timers

// ==== verification/lf_timers_checker.sv ====
/* timing checks on the timer ports
   assumes bound to the timer top */
`timescale 1ns/1ps
module lf_timers_checker
	import lf_timers_pkg::*;
(
	input wire logic MCLK, RST, CS_N, OE_FILTER_EN, RSSI_MODE,
	input wire logic ALERT_N, ALARM_FLAG, STANDBY, SOFT_RESET,
	input wire logic FILTER_RST, DATA_OUT_EN, DEMOD_DATA_OUT,
	input wire logic [NCH-1:0] CHANNEL_WOKE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	a_alert_level: assert property (ALERT_N == !ALARM_FLAG)
		else $error("alert not inverse of flag");
	a_flag_holds: assert property (ALARM_FLAG && !RSSI_MODE && CS_N && $past(CS_N)
		&& $past(CS_N, 2) && $past(CS_N, 3) |=> ALARM_FLAG) else $error("flag lost");
	a_cmd_quiet: assert property (!$past(CS_N, 3) && !$past(CS_N, 4)
		&& !$past(CS_N, 5) |-> !$rose(ALARM_FLAG)) else $error("alarm during command");
	a_filter_off: assert property (!OE_FILTER_EN && !$past(OE_FILTER_EN)
		|-> !$rose(ALARM_FLAG)) else $error("alarm with filter off");
	a_reset_standby: assert property (SOFT_RESET && !RSSI_MODE
		|=> STANDBY && !SOFT_RESET) else $error("soft reset not to standby");
	a_woke_sticky: assert property (!SOFT_RESET && !RSSI_MODE
		|=> (CHANNEL_WOKE & $past(CHANNEL_WOKE)) == $past(CHANNEL_WOKE))
		else $error("wake bit lost");
	a_pass_awake: assert property (DATA_OUT_EN |-> !FILTER_RST && !STANDBY)
		else $error("data on in reset");
	a_data_gate: assert property (!DATA_OUT_EN |-> !DEMOD_DATA_OUT)
		else $error("data leaks");
	a_rssi_awake: assert property (RSSI_MODE && $past(RSSI_MODE)
		|-> !STANDBY && !SOFT_RESET) else $error("timer active in strength mode");
endmodule // lf_timers_checker
bind lf_wakeup_supervision_timers lf_timers_checker u_chk (.MCLK, .RST, .CS_N,
	.OE_FILTER_EN, .RSSI_MODE, .ALERT_N, .ALARM_FLAG, .STANDBY, .SOFT_RESET,
	.FILTER_RST, .DATA_OUT_EN, .DEMOD_DATA_OUT, .CHANNEL_WOKE);

// ==== verification/lf_host_model.sv ====
/* host model: answers an alert with a command
   assumes a bench delay input */
`timescale 1ns/1ps
module lf_host_model (
	// clock and alert
	input wire logic mclk,
	input wire logic alert_n,
	input wire logic [7:0] delay,
	// select
	output logic cs_n
);
	// after delay cycles, select low for six
	initial begin
		cs_n = 1'b1;
		forever begin
			@(negedge mclk);
			if (alert_n === 1'b0) begin
				repeat (delay) @(negedge mclk);
				cs_n = 1'b0;
				repeat (6) @(negedge mclk);
				cs_n = 1'b1;
			end
		end
	end
endmodule // lf_host_model

// ==== verification/tb_lf_wakeup_supervision_timers.sv ====
/* bench for the supervision timers
   assumes shortened counts and the host model */
`timescale 1ns/1ps
module tb_lf_wakeup_supervision_timers;
	import lf_timers_pkg::*;
	localparam int TC = 4, IC = 12, AC = 24, SC = 4, PC = 2;
	logic mclk, rst, oe, rssi, cs_n, alert_n, flag, stby, srst, frst, den, dout;
	logic [2:0] lf, woke;
	logic [7:0] hmin, lmin, dly;
	logic [8:0] pmax;
	logic [31:0] r = 32'hB455;
	int num_errors = 0, total_checks = 0, n, cyc = 0;
	lf_wakeup_supervision_timers #(.TICK_CYCLES(TC), .INACT_COUNT(IC),
		.ALARM_COUNT(AC), .SETTLE_COUNT(SC), .POST_COUNT(PC)) uut (.MCLK(mclk),
		.RST(rst), .LF_IN(lf), .CS_N(cs_n), .OE_FILTER_EN(oe), .RSSI_MODE(rssi),
		.HEADER_HIGH_MIN(hmin), .HEADER_LOW_MIN(lmin), .HEADER_PERIOD_MAX(pmax),
		.ALERT_N(alert_n), .ALARM_FLAG(flag), .CHANNEL_WOKE(woke), .STANDBY(stby),
		.SOFT_RESET(srst), .FILTER_RST(frst), .DATA_OUT_EN(den), .DEMOD_DATA_OUT(dout));
	lf_host_model host (.mclk(mclk), .alert_n(alert_n), .delay(dly), .cs_n(cs_n));
	// random source
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// clocks in a count of ticks
	function automatic int ticks(input int k);
		return k * TC;
	endfunction
	// awaited conditions
	function bit hit(input int s);
		case (s)
			0: return srst === 1'b1;
			1: return den === 1'b1;
			2: return woke !== 3'h0;
			default: return flag === 1'b0;
		endcase
	endfunction
	task chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task await(input int s, input int lim);
		n = 0;
		while (!hit(s) && n < lim) begin
			@(negedge mclk);
			n++;
		end
		chk(hit(s), 1);
	endtask
	task hold(input logic [2:0] v, input int k);
		lf = v;
		repeat (ticks(k)) @(negedge mclk);
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test;
		end
	end
	initial begin
		rst = 1; lf = 0; oe = 1; rssi = 0; dly = 0; hmin = 2; lmin = 2; pmax = 9'h040;
		repeat (2) @(negedge mclk);
		chk({alert_n, flag, woke, stby, srst, frst, den, dout}, 16'h0214);
		rst = 0;
		// two channels wake, header passes
		r = lfsr(r); hmin = {6'h0, r[1:0]} + 8'h2;
		r = lfsr(r); lmin = {6'h0, r[1:0]} + 8'h2;
		lf = 3'h5;
		repeat (4) @(negedge mclk);
		chk({stby, frst}, 2'h1);
		await(2, ticks(SC + 2));
		chk({woke, frst}, 4'hA);
		hold(3'h5, PC + 1);
		hold(0, 1);
		hold(1, hmin + 1);
		hold(0, lmin + 1);
		lf = 1;
		await(1, 8);
		repeat (3) @(negedge mclk);
		chk(dout, 1);
		lf = 0;
		repeat (4) @(negedge mclk);
		chk(dout, 0);
		await(0, ticks(IC + 2));
		chk(n >= ticks(IC - 1) - 4, 1);
		@(negedge mclk);
		chk({stby, woke}, 4'h8);
		// noise fails the header, alarm, host clears it
		r = lfsr(r); dly = r[7:0] & 8'h1F; hmin = 8'h3;
		hold(1, SC + PC + 1);
		for (int i = 0; i < 20 && alert_n !== 1'b0; i++) begin
			hold(1, 1);
			hold(0, 1);
		end
		chk({alert_n, flag, den, woke}, 16'h0011);
		lf = 0;
		await(3, dly + 20);
		chk(alert_n, 1);
		await(0, ticks(IC + 4));
		// gap restarts settling, drop after settling aborts
		hold(3'h2, 2);
		hold(0, 1);
		lf = 3'h2;
		await(2, ticks(SC + 2));
		chk({n >= ticks(SC - 1), woke}, 4'hA);
		lf = 0;
		await(0, ticks(PC + 1));
		@(negedge mclk);
		chk(stby, 1);
		// filter off skips header, no alarm
		oe = 0; lf = 3'h4;
		await(1, ticks(SC + PC + 3));
		chk(flag, 0);
		lf = 0;
		await(0, ticks(IC + 2));
		oe = 1;
		// strength mode: awake, no settling
		rssi = 1; lf = 1;
		repeat (4) @(negedge mclk);
		chk(stby, 0);
		hold(1, SC + 2);
		chk(woke, 0);
		rssi = 0; lf = 0;
		stop_test;
	end
endmodule // tb_lf_wakeup_supervision_timers
